// file: inc/cizo_cfg.svh
`ifndef CIZO_CFG_SVH
`define CIZO_CFG_SVH

// Opcodes decoded by the execution logic.
`define CIZO_OPC_CARRY_INV 8'hef
`define CIZO_OPC_ZERO_DIR  8'hb0
`define CIZO_OPC_ZERO_PTR  8'hb1

// Register indices; the APB byte address is four times the index.
`define CIZO_FLAGS_IDX 10'h0d5
`define CIZO_STAT_IDX  10'h0d6

// Field positions and reset values.
`define CIZO_CARRY_BIT 7
`define CIZO_BUSY_BIT  0
`define CIZO_FLAGS_RST 8'h00
`define CIZO_ZERO_BYTE 8'h00

// Each instruction handled here completes in this many cycles.
`define CIZO_EXEC_CYCLES 4

`endif

// file: inc/cizo_pkg.sv
package cizo_pkg;

  // Execution sequence, one state per instruction cycle.
  typedef enum logic [2:0] {
    CIZO_IDLE,
    CIZO_C1,
    CIZO_C2,
    CIZO_C3,
    CIZO_C4
  } cizo_state_t;

  // Decoded operation.
  typedef enum logic [1:0] {
    CIZO_OP_NONE,
    CIZO_OP_CARRY,
    CIZO_OP_ZDIR,
    CIZO_OP_ZPTR
  } cizo_op_t;

endpackage

// file: core/cizo_flag_regs.sv
`timescale 1ns/10ps
`include "cizo_cfg.svh"

module cizo_flag_regs (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Execution side.
  input  wire logic        carry_inv,
  input  wire logic        exec_busy,
  output logic      [7:0]  flags
);
  import cizo_pkg::*;

  logic [9:0] idx;
  logic       aligned;
  logic       hit_flags;
  logic       hit_stat;
  logic       setup;
  logic       flag_wr;

  // Decode of the word index and the setup phase.
  assign idx       = paddr[11:2];
  assign aligned   = (paddr[1:0] == 2'h0);
  assign hit_flags = aligned && (idx == `CIZO_FLAGS_IDX);
  assign hit_stat  = aligned && (idx == `CIZO_STAT_IDX);
  assign setup     = psel && !penable;
  assign flag_wr   = psel && penable && pwrite && pready && hit_flags;

  // Zero-wait answer: ready and error are set for the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit_flags && !(hit_stat && !pwrite);
    end
  end

  // Read data is captured in the setup phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      if (hit_flags) begin
        prdata <= {24'h00_0000, flags};
      end else if (hit_stat) begin
        prdata <= {31'h0000_0000, exec_busy};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Flags register; a carry inversion beats a software write of that bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= `CIZO_FLAGS_RST;
    end else begin
      if (flag_wr) begin
        flags <= pwdata[7:0];
      end
      if (carry_inv) begin
        flags[`CIZO_CARRY_BIT] <= !flags[`CIZO_CARRY_BIT];
      end
    end
  end

endmodule // cizo_flag_regs

// file: core/cizo_exec.sv
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`include "cizo_cfg.svh"

// How it works
// - The carry-invert operation writes the inverted carry back into carry.
// - Carry inversion leaves every other status flag untouched.
// - Opcode EF is carry inversion, one byte, done in four cycles.
// - The carry bit lives in the status flags register at index D5.
// - Opcode B0 writes zero to the register named by the operand.
// - Opcode B1 zeroes the register the pointer holds; pointer unchanged.
// - Neither zeroing mode alters any status flag.
module cizo_exec #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  // Clock and reset.
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave for the flags and status registers.
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Decoded instruction from the core.
  input  wire logic              ex_start,
  input  wire logic [7:0]        ex_opcode,
  input  wire logic [7:0]        ex_operand,
  output logic                   ex_accept,
  output logic                   ex_busy,
  output logic                   ex_done,
  // Register file read port.
  output logic                   rf_re,
  output logic      [ADDR_W-1:0] rf_raddr,
  input  wire logic [DATA_W-1:0] rf_rdata,
  // Register file write port.
  output logic                   rf_we,
  output logic      [ADDR_W-1:0] rf_waddr,
  output logic      [DATA_W-1:0] rf_wdata,
  // Status flags seen by the core.
  output logic      [7:0]        flags
);
  import cizo_pkg::*;

  // The operand byte names a register, so data is a byte and addresses are at most a byte.
  generate
    if (DATA_W != 8 || ADDR_W < 1 || ADDR_W > 8) begin : g_bad_param
      $error("cizo_exec supports DATA_W 8 and ADDR_W 1 to 8 only");
    end
  endgenerate

  cizo_state_t       state_r;
  cizo_state_t       state_nxt;
  cizo_op_t          op_r;
  cizo_op_t          op_dec;
  logic [ADDR_W-1:0] operand_r;
  logic [ADDR_W-1:0] ptr_r;
  logic              carry_inv_r;
  logic              accept;

  // Opcode decode; anything else is not taken by this block.
  always_comb begin
    unique case (ex_opcode)
      `CIZO_OPC_CARRY_INV: op_dec = CIZO_OP_CARRY;
      `CIZO_OPC_ZERO_DIR:  op_dec = CIZO_OP_ZDIR;
      `CIZO_OPC_ZERO_PTR:  op_dec = CIZO_OP_ZPTR;
      default:             op_dec = CIZO_OP_NONE;
    endcase
  end

  assign accept = ex_start && (state_r == CIZO_IDLE)
                  && (op_dec != CIZO_OP_NONE);

  // Four-cycle sequence for every accepted instruction.
  always_comb begin
    state_nxt = CIZO_IDLE;
    unique case (state_r)
      CIZO_IDLE: state_nxt = accept ? CIZO_C1 : CIZO_IDLE;
      CIZO_C1:   state_nxt = CIZO_C2;
      CIZO_C2:   state_nxt = CIZO_C3;
      CIZO_C3:   state_nxt = CIZO_C4;
      CIZO_C4:   state_nxt = CIZO_IDLE;
    endcase
  end

  // State, handshake pulses and busy level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= CIZO_IDLE;
      ex_accept <= 1'b0;
      ex_busy   <= 1'b0;
      ex_done   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      ex_accept <= accept;
      ex_busy   <= (state_nxt != CIZO_IDLE);
      ex_done   <= (state_r == CIZO_C4);
    end
  end

  // Latch the operation and its operand byte when taken.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r      <= CIZO_OP_NONE;
      operand_r <= '0;
    end else if (accept) begin
      op_r      <= op_dec;
      operand_r <= ex_operand[ADDR_W-1:0];
    end
  end

  // Pointer mode reads the named register in the first cycle only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_re    <= 1'b0;
      rf_raddr <= '0;
    end else begin
      rf_re <= accept && (op_dec == CIZO_OP_ZPTR);
      if (accept) begin
        rf_raddr <= ex_operand[ADDR_W-1:0];
      end
    end
  end

  // The read answers combinationally; keep the target address.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_r <= '0;
    end else if (state_r == CIZO_C1 && op_r == CIZO_OP_ZPTR) begin
      ptr_r <= rf_rdata[ADDR_W-1:0];
    end
  end

  // One zero write in the third cycle, after the pointer is known.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_we    <= 1'b0;
      rf_waddr <= '0;
      rf_wdata <= `CIZO_ZERO_BYTE;
    end else begin
      rf_we <= (state_r == CIZO_C2)
               && (op_r == CIZO_OP_ZDIR || op_r == CIZO_OP_ZPTR);
      rf_wdata <= `CIZO_ZERO_BYTE;
      if (state_r == CIZO_C2) begin
        rf_waddr <= (op_r == CIZO_OP_ZPTR) ? ptr_r : operand_r;
      end
    end
  end

  // Carry inversion request; zeroing never touches the flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_inv_r <= 1'b0;
    end else begin
      carry_inv_r <= (state_r == CIZO_C2)
                     && (op_r == CIZO_OP_CARRY);
    end
  end

  // Flags and status registers behind the APB slave.
  cizo_flag_regs u_regs (
    .pclk      (pclk),
    .presetn   (presetn),
    .paddr     (paddr),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .carry_inv (carry_inv_r),
    .exec_busy (ex_busy),
    .flags     (flags)
  );

  // Helper terms for the checks below.
  logic sw_flag_wr;
  logic flags_rd_setup;
  assign sw_flag_wr = psel && penable && pwrite && pready
                      && (paddr == {`CIZO_FLAGS_IDX, 2'h0});
  assign flags_rd_setup = psel && !penable && !pwrite
                          && (paddr == {`CIZO_FLAGS_IDX, 2'h0});

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_CARRY_INV: assert property (
    carry_inv_r |=> flags[`CIZO_CARRY_BIT] != $past(flags[`CIZO_CARRY_BIT]))
    else $error("carry was not inverted");

  AST_OTHER_FLAGS: assert property (
    carry_inv_r && !sw_flag_wr |=> flags[6:0] == $past(flags[6:0]))
    else $error("carry inversion disturbed another flag");

  AST_FOUR_CYCLES: assert property (
    accept |=> ex_busy [*4] ##1 (!ex_busy && ex_done))
    else $error("instruction did not finish in four cycles");

  AST_CARRY_TIMING: assert property (
    accept && op_dec == CIZO_OP_CARRY |-> ##3 carry_inv_r ##1 !carry_inv_r)
    else $error("carry inversion not issued once in the third cycle");

  AST_FLAGS_READ: assert property (
    flags_rd_setup |=> pready && prdata == {24'h00_0000, $past(flags)})
    else $error("flags register read returned wrong value");

  AST_ZERO_DIRECT: assert property (
    accept && op_dec == CIZO_OP_ZDIR
    |-> ##3 rf_we && rf_wdata == `CIZO_ZERO_BYTE
            && rf_waddr == $past(ex_operand[ADDR_W-1:0], 3))
    else $error("direct zeroing wrote wrong place or value");

  AST_ZERO_PTR: assert property (
    accept && op_dec == CIZO_OP_ZPTR
    |-> ##3 rf_we && rf_wdata == `CIZO_ZERO_BYTE
            && rf_waddr == $past(rf_rdata[ADDR_W-1:0], 2) ##1 !rf_we)
    else $error("pointer zeroing wrote wrong target");

  AST_NO_FLAG_CHANGE: assert property (
    state_r != CIZO_IDLE && op_r != CIZO_OP_CARRY && !sw_flag_wr
    |=> flags == $past(flags))
    else $error("zeroing changed a flag");

  AST_READ_FIRST: assert property (
    accept && op_dec == CIZO_OP_ZPTR
    |=> rf_re && rf_raddr == $past(ex_operand[ADDR_W-1:0])
        ##1 !rf_re && !rf_we ##1 rf_we)
    else $error("pointer read did not precede target write");

  COV_CARRY: cover property (accept && op_dec == CIZO_OP_CARRY);
  COV_ZDIR:  cover property (accept && op_dec == CIZO_OP_ZDIR);
  COV_ZPTR:  cover property (accept && op_dec == CIZO_OP_ZPTR);
  COV_B2B:   cover property (ex_done ##1 accept);

endmodule // cizo_exec

// file: test/cizo_rf_model.sv
`timescale 1ns/10ps

// Register file stand-in on the far side of the execution logic.
module cizo_rf_model (
  // Clock.
  input  wire logic       pclk,
  // Read port.
  input  wire logic       rf_re,
  input  wire logic [7:0] rf_raddr,
  output logic      [7:0] rf_rdata,
  // Write port.
  input  wire logic       rf_we,
  input  wire logic [7:0] rf_waddr,
  input  wire logic [7:0] rf_wdata
);
  logic [7:0] mem [256];

  // Outside a read strobe the port shows the inverse, never a stale value.
  assign rf_rdata = rf_re ? mem[rf_raddr] : ~mem[rf_raddr];

  // Writes land at the edge that sees the strobe.
  always @(posedge pclk) begin
    if (rf_we) begin
      mem[rf_waddr] <= rf_wdata;
    end
  end
endmodule // cizo_rf_model

// file: test/tb_top.sv
`timescale 1ns/10ps

module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  ex_opcode, ex_operand, rf_raddr, rf_rdata;
  logic [7:0]  rf_waddr, rf_wdata, flags;
  logic        ex_start, ex_accept, ex_busy, ex_done, rf_re, rf_we, er;
  int          miscompares, tests_run, cyc;

  cizo_exec i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .ex_start, .ex_opcode,
    .ex_operand, .ex_accept, .ex_busy, .ex_done, .rf_re, .rf_raddr,
    .rf_rdata, .rf_we, .rf_waddr, .rf_wdata, .flags);
  cizo_rf_model i_rf (.pclk, .rf_re, .rf_raddr, .rf_rdata, .rf_we,
    .rf_waddr, .rf_wdata);

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Compares one value and reports a mismatch at once.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; result lands in rd and er.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Issues one instruction; cyc counts edges from accept to done.
  task run_op(input logic [7:0] opc, input logic [7:0] opn);
    int n;
    ex_start <= 1'b1;
    ex_opcode <= opc;
    ex_operand <= opn;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (ex_accept !== 1'b1 && n < 8);
    ex_start <= 1'b0;
    cyc = 0;
    do begin
      @(posedge pclk);
      cyc++;
    end while (ex_done !== 1'b1 && cyc < 20);
  endtask

  // Reset values, the read-only status word and unmapped places.
  task t_regs;
    apb(1'b0, 12'h354, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b0);
    apb(1'b1, 12'h358, 32'hff);
    chk(er, 1'b1);
    apb(1'b0, 12'h358, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b0);
    apb(1'b0, 12'h100, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("t_regs done");
  endtask

  // Carry inversion both ways, other flags kept.
  task t_carry;
    apb(1'b1, 12'h354, 32'h5a);
    run_op(8'hef, 8'h00);
    chk(cyc, 4);
    chk(flags, 8'hda);
    apb(1'b0, 12'h354, 32'h0);
    chk(rd, 32'hda);
    run_op(8'hef, 8'h00);
    chk(flags, 8'h5a);
    $display("t_carry done");
  endtask

  // Direct and pointer zeroing, flags untouched, then a refused opcode.
  task t_zero;
    i_rf.mem[8'h33] = 8'ha5;
    i_rf.mem[8'h34] = 8'h3c;
    i_rf.mem[8'h10] = 8'h20;
    i_rf.mem[8'h20] = 8'h77;
    run_op(8'hb0, 8'h33);
    chk(cyc, 4);
    chk({i_rf.mem[8'h33], i_rf.mem[8'h34]}, 16'h003c);
    chk(flags, 8'h5a);
    run_op(8'hb1, 8'h10);
    chk(cyc, 4);
    chk({i_rf.mem[8'h20], i_rf.mem[8'h10]}, 16'h0020);
    chk(flags, 8'h5a);
    run_op(8'hb2, 8'h10);
    chk(cyc, 20);
    chk(i_rf.mem[8'h10], 8'h20);
    $display("t_zero done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task print_verdict;
    $display("compares=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence after a 12-cycle reset.
  initial begin
    {psel, penable, pwrite, ex_start} = 4'h0;
    {paddr, pwdata, ex_opcode, ex_operand} = '0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_carry();
    t_zero();
    print_verdict();
  end

  // Cuts a hang short.
  initial begin
    #20000;
    miscompares++;
    print_verdict();
  end
endmodule // tb_top
